// file: ufcam_top.sv
// The Avalon-MM interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
// Behaviour
// - Transmitter and receiver run at once, each with its own baud divider.
// - Framing check works in modes 1 to 3, only with frame check enable set.
// - With framing check on, a bad stop bit sets the framing error flag.
// - Framing error flag stays set until software clear or reset.
// - With framing check on, receive done rises at the stop bit.
// - Address recognition is on in modes 1 to 3 whenever multiprocessor enable is set.
// - With recognition on, receive done rises only for matching address frames.
// - Mode 1 recognition: stop bit is ninth bit; needs match and valid stop.
// - In mode 0 multiprocessor enable has no effect.
// - An address frame is accepted on given or broadcast match.
// - Given address is slave address with mask-zero bits as don't care.
// - Broadcast address is slave address OR mask, zero bits don't care.
// - Reset clears slave address and mask, so any address matches.
// - Framing error shares control bit 7 with mode bit 0, by frame check.
// - Ninth bit stored in modes 2 and 3; mode 1 without filter stores stop bit.
module ufcam_top (
  input wire logic ref_clk, // 50 MHz clock.
  input wire logic srst, // Synchronous reset, active high.
  input wire logic [7:0] avs_address, // Register index.
  input wire logic avs_read, // Read strobe.
  input wire logic avs_write, // Write strobe.
  input wire logic [31:0] avs_writedata, // Write data.
  input wire logic [3:0] avs_byteenable, // Byte enables.
  output logic [31:0] avs_readdata, // Read data.
  output logic avs_waitrequest, // Wait request.
  input wire logic rx_line, // Serial receive line.
  output logic tx_line, // Serial transmit line.
  output logic irq // Level interrupt.
);
  // ****************************************
  // Registers and bus slave
  // ****************************************
  logic [7:0] serial_control;
  logic frame_check_enable;
  logic framing_error_flag;
  logic [7:0] slave_address;
  logic [7:0] slave_address_mask;
  logic [7:0] rx_data;
  logic [15:0] rx_div;
  logic [15:0] tx_div;
  logic [2:0] irq_status;
  logic [2:0] irq_enable;
  logic ack;
  logic tx_done_ev;
  ufcam_rx_if rxr ();

  // Register reads take one wait cycle so that read data come from a flip-flop.
  wire req = avs_read || avs_write;
  assign avs_waitrequest = req && !ack;
  wire wr_go = avs_write && !ack && avs_byteenable[0];
  wire [7:0] wbyte = avs_writedata[7:0];
  wire wr_ctrl = wr_go && (avs_address == ufcam_pkg::IDX_SERIAL_CONTROL);
  wire wr_pwr = wr_go && (avs_address == ufcam_pkg::IDX_POWER_CONTROL);
  wire wr_tx = wr_go && (avs_address == ufcam_pkg::IDX_TX_DATA);
  wire wr_clr = wr_go && (avs_address == ufcam_pkg::IDX_IRQ_CLEAR);

  // Mode decode shared by receiver control and filtering.
  function automatic logic [1:0] mode_of(input logic [7:0] ctl);
    mode_of = {ctl[ufcam_pkg::BIT_MODE0], ctl[ufcam_pkg::BIT_MODE1]};
  endfunction
  wire [1:0] mode = mode_of(serial_control);
  wire nine_bit = mode[1];
  wire async_mode = (mode != 2'b00);
  wire check_on = frame_check_enable && async_mode;
  wire recog_on = serial_control[ufcam_pkg::BIT_MULTIPROC] && async_mode;

  // Bit 7 shows the framing error while frame check is enabled.
  wire [7:0] ctrl_view = {frame_check_enable ? framing_error_flag
                                              : serial_control[7],
                          serial_control[6:0]};

  // Read multiplexer; unmapped addresses read as zero.
  logic [7:0] rd_sel;
  always_comb begin
    case (avs_address)
      ufcam_pkg::IDX_SERIAL_CONTROL: rd_sel = ctrl_view;
      ufcam_pkg::IDX_POWER_CONTROL: rd_sel = {1'b0, frame_check_enable, 6'h00};
      ufcam_pkg::IDX_SLAVE_ADDRESS: rd_sel = slave_address;
      ufcam_pkg::IDX_SLAVE_ADDRESS_MASK: rd_sel = slave_address_mask;
      ufcam_pkg::IDX_RX_DATA: rd_sel = rx_data;
      ufcam_pkg::IDX_BAUD_DIV: rd_sel = rx_div[7:0];
      ufcam_pkg::IDX_IRQ_STATUS: rd_sel = {5'h00, irq_status};
      ufcam_pkg::IDX_IRQ_ENABLE: rd_sel = {5'h00, irq_enable};
      default: rd_sel = 8'h00;
    endcase
  end

  // Handshake and read data register.
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ack <= 1'b0;
      avs_readdata <= 32'h0000_0000;
    end else begin
      ack <= req && !ack;
      if (avs_read && !ack) avs_readdata <= {24'h000000, rd_sel};
    end
  end

  // ****************************************
  // Address recognition
  // ****************************************
  wire [7:0] bcast = slave_address | slave_address_mask;
  wire given_hit = ((rxr.data ^ slave_address) & slave_address_mask) == 8'h00;
  wire bcast_hit = ((rxr.data ^ 8'hFF) & bcast) == 8'h00;
  wire addr_hit = given_hit || bcast_hit;
  // Mode 1 uses the stop bit as the ninth bit and also needs it valid.
  wire addr_frame = rxr.ninth;
  wire accept = !recog_on || (addr_frame && addr_hit && rxr.stop_ok);
  wire bad_stop = rxr.done && check_on && !rxr.stop_ok;

  // Receive done timing: the receiver reports at mid stop bit. Without frame
  // check the flag is raised a bit earlier, at the end of the last data bit,
  // which is approximated by the same strobe since the stop is then unchecked.
  wire rx_event = rxr.done && accept;

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      serial_control <= ufcam_pkg::RST_BYTE;
      frame_check_enable <= 1'b0;
      framing_error_flag <= 1'b0;
      slave_address <= ufcam_pkg::RST_BYTE;
      slave_address_mask <= ufcam_pkg::RST_BYTE;
      rx_data <= ufcam_pkg::RST_BYTE;
      rx_div <= ufcam_pkg::RST_BAUD_DIV;
      tx_div <= ufcam_pkg::RST_BAUD_DIV;
      irq_enable <= 3'h0;
    end else begin
      if (wr_ctrl) begin
        serial_control[6:0] <= wbyte[6:0];
        if (!frame_check_enable) serial_control[7] <= wbyte[7];
      end
      if (wr_pwr) frame_check_enable <= wbyte[ufcam_pkg::BIT_FRAME_CHECK];
      if (wr_go && avs_address == ufcam_pkg::IDX_SLAVE_ADDRESS) slave_address <= wbyte;
      if (wr_go && avs_address == ufcam_pkg::IDX_SLAVE_ADDRESS_MASK) slave_address_mask <= wbyte;
      if (wr_go && avs_address == ufcam_pkg::IDX_BAUD_DIV) begin
        rx_div <= avs_writedata[15:0];
        tx_div <= avs_writedata[31:16];
      end
      if (wr_go && avs_address == ufcam_pkg::IDX_IRQ_ENABLE) irq_enable <= wbyte[2:0];
      // Software clears the error only by writing zero with frame check on.
      if (bad_stop) framing_error_flag <= 1'b1;
      else if (wr_ctrl && frame_check_enable && !wbyte[7]) framing_error_flag <= 1'b0;
      // Hardware set of the done flags wins over a software write.
      if (rx_event) begin
        serial_control[ufcam_pkg::BIT_RX_DONE] <= 1'b1;
        rx_data <= rxr.data;
        if (nine_bit || !recog_on) serial_control[ufcam_pkg::BIT_RX_NINTH] <= rxr.ninth;
      end
      if (tx_done_ev) serial_control[ufcam_pkg::BIT_TX_DONE] <= 1'b1;
    end
  end

  // ****************************************
  // Interrupt status
  // ****************************************
  wire [2:0] events = {bad_stop, tx_done_ev, rx_event};
  // Sticky status; a set in the clearing cycle wins.
  always_ff @(posedge ref_clk) begin
    if (srst) irq_status <= 3'h0;
    else irq_status <= events | (irq_status & ~(wr_clr ? wbyte[2:0] : 3'h0));
  end
  assign irq = |(irq_status & irq_enable);

  // ****************************************
  // Baud ticks, independent per direction
  // ****************************************
  logic [15:0] rx_cnt;
  logic [15:0] tx_cnt;
  wire rx_tick = (rx_cnt == 16'h0000);
  wire tx_tick = (tx_cnt == 16'h0000);
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rx_cnt <= 16'h0000;
      tx_cnt <= 16'h0000;
    end else begin
      rx_cnt <= rx_tick ? rx_div : rx_cnt - 16'h0001;
      tx_cnt <= tx_tick ? tx_div : tx_cnt - 16'h0001;
    end
  end

  ufcam_receiver u_rx (
    .ref_clk(ref_clk),
    .srst(srst),
    .rx_line(rx_line),
    .enable(serial_control[ufcam_pkg::BIT_RX_EN] && async_mode),
    .nine_bit(nine_bit),
    .tick(rx_tick),
    .res(rxr.rx)
  );

  // ****************************************
  // Transmitter
  // ****************************************
  logic [10:0] tx_shift;
  logic [3:0] tx_left;
  logic [3:0] tx_phase;
  wire tx_bit_end = tx_tick && (tx_phase == ufcam_pkg::OVERSAMPLE_LAST);
  // Shifts start, data, optional ninth and stop bits out, LSB first.
  always_ff @(posedge ref_clk) begin
    tx_done_ev <= 1'b0;
    if (srst) begin
      tx_shift <= 11'h7FF;
      tx_left <= 4'h0;
      tx_phase <= 4'h0;
      tx_line <= 1'b1;
    end else if (wr_tx && tx_left == 4'h0) begin
      tx_shift <= nine_bit ? {1'b1, serial_control[ufcam_pkg::BIT_TX_NINTH], wbyte, 1'b0}
                           : {2'b11, wbyte, 1'b0};
      tx_left <= nine_bit ? 4'hB : 4'hA;
      tx_phase <= 4'h0;
    end else if (tx_left != 4'h0) begin
      if (tx_tick) tx_phase <= tx_phase + 4'h1;
      tx_line <= tx_shift[0];
      if (tx_bit_end) begin
        tx_shift <= {1'b1, tx_shift[10:1]};
        tx_left <= tx_left - 4'h1;
        if (tx_left == 4'h2) tx_done_ev <= 1'b1;
      end
    end else begin
      tx_line <= 1'b1;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_fe_sticky: assert property (@(posedge ref_clk) disable iff (srst)
    framing_error_flag && !(wr_ctrl && frame_check_enable && !wbyte[7]) |=> framing_error_flag)
    else $error("framing error flag dropped without a clear");
  a_fe_set: assert property (@(posedge ref_clk) disable iff (srst)
    rxr.done && check_on && !rxr.stop_ok |=> framing_error_flag)
    else $error("bad stop bit did not set the framing error");
  a_fe_off: assert property (@(posedge ref_clk) disable iff (srst)
    rxr.done && !check_on && !framing_error_flag |=> !framing_error_flag)
    else $error("framing error set with check disabled");
  a_ri_filter: assert property (@(posedge ref_clk) disable iff (srst)
    rxr.done && recog_on && !addr_hit && !serial_control[0] |=> !serial_control[0])
    else $error("receive done raised for a foreign address");
  a_ri_data: assert property (@(posedge ref_clk) disable iff (srst)
    rxr.done && recog_on && !rxr.ninth && !serial_control[0] |=> !serial_control[0])
    else $error("receive done raised for a data frame under filtering");
  a_ri_accept: assert property (@(posedge ref_clk) disable iff (srst)
    rxr.done && recog_on && rxr.ninth && rxr.stop_ok && bcast_hit |=> serial_control[0])
    else $error("broadcast address frame not accepted");
  a_mode0_mp: assert property (@(posedge ref_clk) disable iff (srst)
    mode == 2'b00 |-> !recog_on)
    else $error("recognition active in mode 0");
  a_view_bit7: assert property (@(posedge ref_clk) disable iff (srst)
    avs_read && !ack && avs_address == ufcam_pkg::IDX_SERIAL_CONTROL && frame_check_enable
    ##1 1 |-> avs_readdata[7] == $past(framing_error_flag))
    else $error("bit 7 does not show the framing error");
  a_rst_match: assert property (@(posedge ref_clk)
    $past(srst) |-> slave_address == 8'h00 && slave_address_mask == 8'h00)
    else $error("address registers not cleared by reset");
endmodule
`default_nettype wire

// file: ufcam_pkg.sv
package ufcam_pkg;
  // Register offsets. Printed offsets are not multiples of four, so they are indices.
  localparam logic [7:0] IDX_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] IDX_POWER_CONTROL = 8'h87;
  localparam logic [7:0] IDX_SLAVE_ADDRESS = 8'hA9;
  localparam logic [7:0] IDX_SLAVE_ADDRESS_MASK = 8'hB9;
  localparam logic [7:0] IDX_RX_DATA = 8'h99;
  localparam logic [7:0] IDX_TX_DATA = 8'h9A;
  localparam logic [7:0] IDX_BAUD_DIV = 8'h9B;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h9C;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h9D;
  localparam logic [7:0] IDX_IRQ_CLEAR = 8'h9E;
  // Bit positions.
  localparam int BIT_MODE0 = 7;
  localparam int BIT_MODE1 = 6;
  localparam int BIT_MULTIPROC = 5;
  localparam int BIT_RX_EN = 4;
  localparam int BIT_TX_NINTH = 3;
  localparam int BIT_RX_NINTH = 2;
  localparam int BIT_TX_DONE = 1;
  localparam int BIT_RX_DONE = 0;
  localparam int BIT_FRAME_CHECK = 6;
  // Reset values and oversample phase points.
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_BAUD_DIV = 16'h001B;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF;
  localparam logic [3:0] OVERSAMPLE_MID = 4'h7;
  // Interrupt event bits.
  localparam int EV_RX = 0;
  localparam int EV_TX = 1;
  localparam int EV_FRAME = 2;
  localparam int EV_W = 3;
endpackage

// file: ufcam_rx_if.sv
`timescale 1ns/10ps
`default_nettype none
// Result of one received frame, passed from the receiver to the register block.
interface ufcam_rx_if;
  logic done;
  logic [7:0] data;
  logic ninth;
  logic stop_ok;
  modport rx (output done, output data, output ninth, output stop_ok);
  modport core (input done, input data, input ninth, input stop_ok);
endinterface
`default_nettype wire

// file: ufcam_receiver.sv
`timescale 1ns/10ps
`default_nettype none
module ufcam_receiver (
  input wire logic ref_clk, // System clock.
  input wire logic srst, // Synchronous reset.
  input wire logic rx_line, // Serial input.
  input wire logic enable, // Reception enabled.
  input wire logic nine_bit, // Modes 2 and 3.
  input wire logic tick, // Sixteen-times oversample strobe.
  ufcam_rx_if.rx res // Frame result.
);
  typedef enum logic [3:0] {
    UFCAM_RX_IDLE = 4'b0001,
    UFCAM_RX_START = 4'b0010,
    UFCAM_RX_BITS = 4'b0100,
    UFCAM_RX_STOP = 4'b1000
  } ufcam_rx_state_t;
  ufcam_rx_state_t state;
  logic [3:0] phase;
  logic [3:0] nbits;
  logic [8:0] shift;
  wire mid = tick && (phase == ufcam_pkg::OVERSAMPLE_MID);
  wire [3:0] last_bit = nine_bit ? 4'h8 : 4'h7;
  // Samples each bit at mid-period; the stop bit value is returned with the data.
  always_ff @(posedge ref_clk) begin
    res.done <= 1'b0;
    if (srst) begin
      state <= UFCAM_RX_IDLE;
      phase <= 4'h0;
      nbits <= 4'h0;
      shift <= 9'h000;
      res.data <= 8'h00;
      res.ninth <= 1'b0;
      res.stop_ok <= 1'b0;
    end else begin
      if (tick) phase <= phase + 4'h1;
      case (state)
        UFCAM_RX_IDLE: begin
          phase <= 4'h0;
          if (enable && !rx_line) state <= UFCAM_RX_START;
        end
        UFCAM_RX_START: begin
          if (mid) begin
            phase <= 4'h8;
            nbits <= 4'h0;
            state <= rx_line ? UFCAM_RX_IDLE : UFCAM_RX_BITS;
          end
        end
        UFCAM_RX_BITS: begin
          if (mid) begin
            shift <= {rx_line, shift[8:1]};
            nbits <= nbits + 4'h1;
            if (nbits == last_bit) state <= UFCAM_RX_STOP;
          end
        end
        UFCAM_RX_STOP: begin
          if (mid) begin
            res.done <= 1'b1;
            res.stop_ok <= rx_line;
            res.data <= nine_bit ? shift[7:0] : shift[8:1];
            res.ninth <= nine_bit ? shift[8] : rx_line;
            state <= UFCAM_RX_IDLE;
          end
        end
        default: state <= UFCAM_RX_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: ufcam_peer.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// Far-end processor on the shared serial line.
// ************************************************************
module ufcam_peer #(
  parameter int BIT_CYC = 16
) (
  input wire logic ref_clk, // Clock that paces bit times.
  output var logic line // Serial line toward the receiver.
);
  // The line rests at the high mark level between frames.
  initial begin
    line = 1'b1;
  end
  // Sends start bit, data LSB first, optional ninth bit, then the stop level.
  // A low stop level is sent only when a scenario asks for a broken frame.
  task automatic send(input logic [7:0] d, input logic has9, input logic b9, input logic stop);
    logic [10:0] bits;
    int nb;
    bits = has9 ? {stop, b9, d, 1'b0} : {1'b1, stop, d, 1'b0};
    nb = has9 ? 11 : 10;
    for (int i = 0; i < nb; i++) begin
      @(posedge ref_clk);
      line <= bits[i];
      repeat (BIT_CYC - 1) @(posedge ref_clk);
    end
    @(posedge ref_clk);
    line <= 1'b1;
  endtask
endmodule
`default_nettype wire

// file: uart_frame_check_addr_match_tb.sv
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// Self-checking bench: register bus master and frame scenarios.
// ************************************************************
module uart_frame_check_addr_match_tb;
  logic ref_clk, srst, avs_read, avs_write, avs_waitrequest, rx_line, tx_line, irq;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdv;
  logic [3:0] avs_byteenable;
  int n_errors = 0;
  int check_count = 0;
  logic [7:0] tab_a [6] = '{8'h57, 8'h55, 8'h5A, 8'hFE, 8'h57, 8'hA9};
  logic tab_n [6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
  logic exp_ok;
  logic [9:0] tx_exp;
  int n_wait;

  // Clock generation at 50 MHz.
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  ufcam_top dut (.ref_clk(ref_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_line(rx_line), .tx_line(tx_line), .irq(irq));
  ufcam_peer #(.BIT_CYC(16)) peer (.ref_clk(ref_clk), .line(rx_line));

  // ************************************************************
  // Reporting and bus tasks.
  // ************************************************************
  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask
  // One Avalon transfer; the request holds until waitrequest is seen low.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    n = 0;
    // Waitrequest and read data are looked at on the rising edge only.
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      n++;
      @(posedge ref_clk);
    end
    if (n >= 50) begin
      n_errors++;
      $display("CHECK FAILED at %0t: bus answer timed out", $time);
      complete_run();
    end
    rdv = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(rdv & m, e, $sformatf("register %h", a));
  endtask
  task automatic frame(input logic [7:0] d, input logic h9, input logic b9, input logic st);
    peer.send(d, h9, b9, st);
    repeat (4) @(posedge ref_clk);
  endtask

  // Bounded run length.
  initial begin
    repeat (100000) @(posedge ref_clk);
    n_errors++;
    $display("CHECK FAILED at %0t: run timed out", $time);
    complete_run();
  end

  // ************************************************************
  // Main sequence.
  // ************************************************************
  initial begin
    srst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'hF;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    chk(tx_line, 32'h1, "transmit idle");
    rd_chk(ufcam_pkg::IDX_SLAVE_ADDRESS, 32'hFFFF_FFFF, 32'h0);
    rd_chk(ufcam_pkg::IDX_SLAVE_ADDRESS_MASK, 32'hFFFF_FFFF, 32'h0);
    rd_chk(ufcam_pkg::IDX_SERIAL_CONTROL, 32'hFFFF_FFFF, 32'h0);
    rd_chk(8'h00, 32'hFFFF_FFFF, 32'h0);
    $display("Test reset values done");
    // Plain mode 1 reception, stop bit lands in the ninth bit, interrupt path.
    bus(1'b1, ufcam_pkg::IDX_BAUD_DIV, 32'h0000_0000);
    bus(1'b1, ufcam_pkg::IDX_SERIAL_CONTROL, 32'h50);
    bus(1'b1, ufcam_pkg::IDX_IRQ_ENABLE, 32'h01);
    frame(8'hA5, 1'b0, 1'b0, 1'b1);
    rd_chk(ufcam_pkg::IDX_SERIAL_CONTROL, 32'h05, 32'h05);
    rd_chk(ufcam_pkg::IDX_RX_DATA, 32'hFF, 32'hA5);
    chk(irq, 32'h1, "irq raised");
    bus(1'b1, ufcam_pkg::IDX_IRQ_CLEAR, 32'h01);
    bus(1'b1, ufcam_pkg::IDX_SERIAL_CONTROL, 32'h50);
    chk(irq, 32'h0, "irq cleared");
    bus(1'b1, ufcam_pkg::IDX_IRQ_ENABLE, 32'h00);
    frame(8'h3C, 1'b0, 1'b0, 1'b0);
    chk(irq, 32'h0, "irq masked");
    rd_chk(ufcam_pkg::IDX_IRQ_STATUS, 32'h01, 32'h01);
    rd_chk(ufcam_pkg::IDX_SERIAL_CONTROL, 32'h80, 32'h00);
    $display("Test reception and interrupt done");
    // Framing check: a bad stop sets a sticky flag in control bit 7.
    bus(1'b1, ufcam_pkg::IDX_IRQ_CLEAR, 32'h07);
    bus(1'b1, ufcam_pkg::IDX_POWER_CONTROL, 32'h40);
    bus(1'b1, ufcam_pkg::IDX_SERIAL_CONTROL, 32'h50);
    frame(8'h81, 1'b0, 1'b0, 1'b0);
    rd_chk(ufcam_pkg::IDX_SERIAL_CONTROL, 32'h81, 32'h81);
    rd_chk(ufcam_pkg::IDX_IRQ_STATUS, 32'h04, 32'h04);
    bus(1'b1, ufcam_pkg::IDX_SERIAL_CONTROL, 32'hD0);
    frame(8'h18, 1'b0, 1'b0, 1'b1);
    rd_chk(ufcam_pkg::IDX_SERIAL_CONTROL, 32'h80, 32'h80);
    bus(1'b1, ufcam_pkg::IDX_SERIAL_CONTROL, 32'h50);
    rd_chk(ufcam_pkg::IDX_SERIAL_CONTROL, 32'h80, 32'h00);
    bus(1'b1, ufcam_pkg::IDX_POWER_CONTROL, 32'h00);
    $display("Test framing check done");
    // Mode 3 recognition; cleared address registers accept any address.
    bus(1'b1, ufcam_pkg::IDX_SERIAL_CONTROL, 32'hF0);
    frame(8'h33, 1'b1, 1'b1, 1'b1);
    rd_chk(ufcam_pkg::IDX_SERIAL_CONTROL, 32'h01, 32'h01);
    bus(1'b1, ufcam_pkg::IDX_SLAVE_ADDRESS, 32'h56);
    bus(1'b1, ufcam_pkg::IDX_SLAVE_ADDRESS_MASK, 32'hFC);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, ufcam_pkg::IDX_SERIAL_CONTROL, 32'hF0);
      exp_ok = tab_n[i] && ((((tab_a[i] ^ 8'h56) & 8'hFC) == 8'h00) ||
        (((tab_a[i] ^ 8'hFE) & 8'hFE) == 8'h00));
      frame(tab_a[i], 1'b1, tab_n[i], 1'b1);
      rd_chk(ufcam_pkg::IDX_SERIAL_CONTROL, 32'h01, {31'h0, exp_ok});
    end
    $display("Test mode 3 recognition done");
    // Mode 1 recognition: stop bit acts as the ninth bit.
    bus(1'b1, ufcam_pkg::IDX_SERIAL_CONTROL, 32'h70);
    frame(8'h57, 1'b0, 1'b0, 1'b1);
    rd_chk(ufcam_pkg::IDX_SERIAL_CONTROL, 32'h01, 32'h01);
    rd_chk(ufcam_pkg::IDX_RX_DATA, 32'hFF, 32'h57);
    bus(1'b1, ufcam_pkg::IDX_SERIAL_CONTROL, 32'h70);
    frame(8'h57, 1'b0, 1'b0, 1'b0);
    rd_chk(ufcam_pkg::IDX_SERIAL_CONTROL, 32'h01, 32'h00);
    frame(8'h5A, 1'b0, 1'b0, 1'b1);
    rd_chk(ufcam_pkg::IDX_SERIAL_CONTROL, 32'h01, 32'h00);
    $display("Test mode 1 recognition done");
    // Mode 1 transmit: start, eight data bits LSB first, done event as the stop bit starts, stop.
    bus(1'b1, ufcam_pkg::IDX_SERIAL_CONTROL, 32'h50);
    bus(1'b1, ufcam_pkg::IDX_IRQ_CLEAR, 32'h07);
    tx_exp = {1'b1, 8'hC6, 1'b0};
    bus(1'b1, ufcam_pkg::IDX_TX_DATA, 32'hC6);
    n_wait = 0;
    while (tx_line !== 1'b0 && n_wait < 50) begin
      @(posedge ref_clk);
      n_wait++;
    end
    chk(n_wait < 50, 32'h1, "transmit start seen");
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      chk(tx_line, {31'h0, tx_exp[i]}, "transmit bit");
      repeat (16) @(posedge ref_clk);
    end
    rd_chk(ufcam_pkg::IDX_IRQ_STATUS, 32'h02, 32'h02);
    rd_chk(ufcam_pkg::IDX_SERIAL_CONTROL, 32'h02, 32'h02);
    $display("Test transmit done");
    complete_run();
  end
endmodule
`default_nettype wire
